// *** rtl/rlic_pkg.sv ***
/*
  Package of the logical-input control block: carrier structs, the
  defaults of unmapped logical inputs, the register map and timing counts.
  Assumes a 250 MHz processing clock.
*/
package rlic_pkg;

    // Logical inputs; one bit each, the user inputs as a vector
    typedef struct packed {
        logic        phase_dir_toc_enable;
        logic        ground_dir_toc_enable;
        logic [15:0] user_logic_inputs;
        logic        counter_clear_input;
        logic        user_message_input;
        logic        external_failure_starter;
        logic        failure_trip_initiate;
        logic        trip_reclose_test;
        logic        reclose_inhibit;
        logic        breaker_aux_a;
        logic        breaker_aux_b;
        logic        recloser_enable;
        logic        sensitive_earth_enable;
    } rlic_li_t;

    // Level read by an input that is mapped to nothing
    localparam rlic_li_t LI_DEFAULT = '{
        phase_dir_toc_enable:     1'b1,
        ground_dir_toc_enable:    1'b1,
        user_logic_inputs:        16'h0000,
        counter_clear_input:      1'b0,
        user_message_input:       1'b0,
        external_failure_starter: 1'b0,
        failure_trip_initiate:    1'b0,
        trip_reclose_test:        1'b0,
        reclose_inhibit:          1'b0,
        breaker_aux_a:            1'b0,
        breaker_aux_b:            1'b0,
        recloser_enable:          1'b1,
        sensitive_earth_enable:   1'b1
    };

    // Element supervision enables
    typedef struct packed {
        logic phase_dir_toc;
        logic ground_dir_toc;
        logic sensitive_earth;
        logic recloser;
    } rlic_en_t;

    // Breaker position as decoded
    typedef struct packed {
        logic closed;
        logic open;
        logic unknown;
    } rlic_pos_t;

    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_RC_CNT  = 8'h08;
    localparam logic [7:0] ADDR_OC_CNT  = 8'h0c;

    // Control register fields
    localparam int CTRL_SINGLE_BIT = 0;
    localparam int CTRL_SEF_BIT    = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;

    // Status register fields
    localparam int ST_CLOSED_BIT    = 0;
    localparam int ST_OPEN_BIT      = 1;
    localparam int ST_UNKNOWN_BIT   = 2;
    localparam int ST_PEND_BIT      = 3;
    localparam int ST_TRIPFAIL_BIT  = 4;
    localparam int ST_CLOSEFAIL_BIT = 5;
    localparam int ST_USERMSG_BIT   = 6;
    localparam int ST_RECOUT_BIT    = 7;
    localparam int ST_STEP_LSB      = 8;

    // Recloser steps before lockout
    localparam logic [2:0] MAX_STEPS = 3'h4;

    // Timing
    localparam longint CLK_HZ        = 250_000_000;
    localparam int     ALT_TIME_S    = 1;
    localparam int     OPEN_TIME_MS  = 500;
    localparam int     RESET_TIME_MS = 1000;
    localparam int     FAIL_TIME_MS  = 200;
    localparam int ALT_CYC   = int'(CLK_HZ * ALT_TIME_S);
    localparam int OPEN_CYC  = int'(CLK_HZ / 1000 * OPEN_TIME_MS);
    localparam int RESET_CYC = int'(CLK_HZ / 1000 * RESET_TIME_MS);
    localparam int FAIL_CYC  = int'(CLK_HZ / 1000 * FAIL_TIME_MS);
    localparam int TMR_W     = 28;

endpackage

// *** rtl/rlic_top.sv ***
/*
  Logical-input control of a distribution protection relay: resolves mapped
  logical inputs against their defaults, gives element enables, decodes
  breaker position, runs counters, display alternation, breaker-failure
  starts, the trip/reclose test sequence and close supervision.
  Assumes inputs synchronous to i_clk and one-cycle pulse command inputs.
*/
// Function
// - Phase directional element enabled; unmapped high
// - Ground directional element enabled; unmapped high
// - Sixteen user logic inputs, unmapped low
// - Counter clear zeroes both counters
// - User message alternates display each second
// - External starter begins breaker-failure sequence
// - Initiate input starts breaker-failure trip logic
// - Held test input keeps tripping through steps
// - Pulsed test input gives one trip/reclose
// - Reclose inhibit freezes open timer, resumes
// - Reclose inhibit leaves reset timer alone
// - Aux a high, b low: closed
// - Aux a low, b high: open
// - Equal aux levels, two-contact mode: status unknown, displayed
// - Unassigned aux inputs read low
// - Both contacts drive close/failure outputs, except single-contact
// - Recloser runs only when enabled; else target
// - Sensitive earth enabled by input; unmapped high
// - Close held while unknown; run if open
`timescale 1ns/1ns
module rlic_top
    import rlic_pkg::*;
#(
    parameter int P_ALT_CYC   = ALT_CYC,
    parameter int P_OPEN_CYC  = OPEN_CYC,
    parameter int P_RESET_CYC = RESET_CYC,
    parameter int P_FAIL_CYC  = FAIL_CYC
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire rlic_li_t    i_li_value,
    input  wire rlic_li_t    i_li_mapped,
    input  wire logic        i_close_cmd,
    input  wire logic        i_overcurrent_trip,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rd_data,
    output rlic_en_t         o_enable,
    output logic [15:0]      o_user_logic_inputs,
    output rlic_pos_t        o_breaker,
    output logic             o_display_user_msg,
    output logic             o_display_cb_unknown,
    output logic             o_recloser_out_target,
    output logic             o_bf_external_start,
    output logic             o_bf_initiate,
    output logic             o_trip,
    output logic             o_close,
    output logic             o_trip_fail,
    output logic             o_close_fail,
    output logic [2:0]       o_recloser_step
);

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_OPEN,
        SEQ_RESET,
        SEQ_LOCK
    } rlic_seq_t;

    typedef enum logic [1:0] {
        SUP_NONE,
        SUP_TRIP,
        SUP_CLOSE
    } rlic_sup_t;

    typedef struct packed {
        rlic_li_t             li;
        logic                 trip_reclose_test_prev;
        rlic_seq_t            seq;
        logic [2:0]           step;
        logic [TMR_W-1:0]     open_tmr;
        logic [TMR_W-1:0]     reset_tmr;
        logic [TMR_W-1:0]     alt_tmr;
        logic                 show_user;
        logic [15:0]          rc_cnt;
        logic [15:0]          oc_cnt;
        logic                 close_pend;
        rlic_sup_t            sup;
        logic [TMR_W-1:0]     sup_tmr;
        logic                 trip_fail;
        logic                 close_fail;
        logic                 trip;
        logic                 close;
        logic [1:0]           ctrl;
        logic [31:0]          rd_data;
    } rlic_state_t;

    rlic_state_t r;
    rlic_state_t next_r;

    rlic_li_t  li_res;
    rlic_pos_t pos;
    logic      single;
    logic      rec_en;
    logic      trip_req;
    logic      close_req;

    // Unmapped inputs take their defaults
    // per-bit default select
    assign li_res = rlic_li_t'((i_li_value & i_li_mapped) | (LI_DEFAULT & ~i_li_mapped));

    assign single = r.ctrl[CTRL_SINGLE_BIT];
    assign rec_en = r.li.recloser_enable;

    // Position decode from the sampled contacts
    always_comb
    begin
        // single-contact mode uses aux a only
        if (single)
        begin
            pos.closed  = r.li.breaker_aux_a;
            pos.open    = ~r.li.breaker_aux_a;
            pos.unknown = 1'b0;
        end
        else
        begin
            pos.closed  = r.li.breaker_aux_a & ~r.li.breaker_aux_b;
            pos.open    = ~r.li.breaker_aux_a & r.li.breaker_aux_b;
            pos.unknown = ~(r.li.breaker_aux_a ^ r.li.breaker_aux_b);
        end
    end

    always_comb
    begin
        next_r       = r;
        next_r.trip  = 1'b0;
        next_r.close = 1'b0;
        trip_req     = 1'b0;
        close_req    = 1'b0;

        next_r.li        = li_res;
        next_r.trip_reclose_test_prev = r.li.trip_reclose_test;

        if (!r.li.user_message_input)
        begin
            next_r.alt_tmr   = '0;
            next_r.show_user = 1'b0;
        end
        else if (r.alt_tmr >= TMR_W'(P_ALT_CYC - 1))
        begin
            next_r.alt_tmr   = '0;
            next_r.show_user = ~r.show_user;
        end
        else
        begin
            next_r.alt_tmr = r.alt_tmr + 1'b1;
        end

        // Trip/reclose test sequence
        case (r.seq)
            SEQ_IDLE:
            begin
                if (r.li.trip_reclose_test && !r.trip_reclose_test_prev)
                begin
                    trip_req        = 1'b1;
                    next_r.open_tmr = '0;
                    next_r.seq      = SEQ_OPEN;
                end
            end
            SEQ_OPEN:
            begin
                if (!r.li.reclose_inhibit)
                begin
                    next_r.open_tmr = r.open_tmr + 1'b1;
                end
                if (!rec_en)
                begin
                    next_r.seq = SEQ_LOCK;
                end
                else if (r.open_tmr >= TMR_W'(P_OPEN_CYC - 1) && !r.li.reclose_inhibit)
                begin
                    close_req        = 1'b1;
                    next_r.step      = r.step + 1'b1;
                    next_r.rc_cnt    = r.rc_cnt + 1'b1;
                    next_r.reset_tmr = '0;
                    next_r.seq       = SEQ_RESET;
                end
            end
            SEQ_RESET:
            begin
                next_r.reset_tmr = r.reset_tmr + 1'b1;
                // held input trips the next step
                if (r.li.trip_reclose_test)
                begin
                    if (r.step >= MAX_STEPS)
                    begin
                        next_r.seq = SEQ_LOCK;
                    end
                    else
                    begin
                        trip_req        = 1'b1;
                        next_r.open_tmr = '0;
                        next_r.seq      = SEQ_OPEN;
                    end
                end
                else if (r.reset_tmr >= TMR_W'(P_RESET_CYC - 1))
                begin
                    next_r.step = '0;
                    next_r.seq  = SEQ_IDLE;
                end
            end
            SEQ_LOCK:
            begin
                // Lockout until the test input drops
                if (!r.li.trip_reclose_test)
                begin
                    next_r.step = '0;
                    next_r.seq  = SEQ_IDLE;
                end
            end
            default:
            begin
                next_r.seq = SEQ_IDLE;
            end
        endcase

        // held close resolves with the status
        if (r.close_pend && !pos.unknown)
        begin
            next_r.close_pend = 1'b0;
            if (pos.open)
            begin
                close_req = 1'b1;
            end
        end
        if (i_close_cmd)
        begin
            if (pos.unknown)
            begin
                next_r.close_pend = 1'b1;
            end
            else if (pos.open)
            begin
                close_req = 1'b1;
            end
        end

        next_r.trip  = trip_req;
        next_r.close = close_req;

        if (trip_req)
        begin
            next_r.sup       = SUP_TRIP;
            next_r.sup_tmr   = '0;
            next_r.trip_fail = 1'b0;
        end
        else if (close_req)
        begin
            next_r.sup        = SUP_CLOSE;
            next_r.sup_tmr    = '0;
            next_r.close_fail = 1'b0;
        end
        else if (r.sup == SUP_TRIP && pos.open)
        begin
            next_r.sup = SUP_NONE;
        end
        else if (r.sup == SUP_CLOSE && pos.closed)
        begin
            next_r.sup = SUP_NONE;
        end
        else if (r.sup != SUP_NONE)
        begin
            if (r.sup_tmr >= TMR_W'(P_FAIL_CYC - 1))
            begin
                next_r.trip_fail  = r.trip_fail | (r.sup == SUP_TRIP);
                next_r.close_fail = r.close_fail | (r.sup == SUP_CLOSE);
                next_r.sup        = SUP_NONE;
            end
            else
            begin
                next_r.sup_tmr = r.sup_tmr + 1'b1;
            end
        end
        if ((trip_req || close_req) && r.sup_tmr >= TMR_W'(P_FAIL_CYC - 1))
        begin
            next_r.trip_fail  |= r.sup == SUP_TRIP && !pos.open;
            next_r.close_fail |= r.sup == SUP_CLOSE && !pos.closed;
        end

        if (i_overcurrent_trip && r.oc_cnt != 16'hffff)
        begin
            next_r.oc_cnt = r.oc_cnt + 1'b1;
        end
        if (r.li.counter_clear_input)
        begin
            next_r.rc_cnt = '0;
            next_r.oc_cnt = '0;
        end

        // Register port
        if (i_wr && i_addr == ADDR_CTRL)
        begin
            next_r.ctrl = i_wr_data[1:0];
        end
        next_r.rd_data = '0;
        if (i_rd)
        begin
            case (i_addr)
                ADDR_CTRL:
                begin
                    next_r.rd_data[1:0] = r.ctrl;
                end
                ADDR_STATUS:
                begin
                    next_r.rd_data[ST_CLOSED_BIT]    = pos.closed;
                    next_r.rd_data[ST_OPEN_BIT]      = pos.open;
                    next_r.rd_data[ST_UNKNOWN_BIT]   = pos.unknown;
                    next_r.rd_data[ST_PEND_BIT]      = r.close_pend;
                    next_r.rd_data[ST_TRIPFAIL_BIT]  = r.trip_fail;
                    next_r.rd_data[ST_CLOSEFAIL_BIT] = r.close_fail;
                    next_r.rd_data[ST_USERMSG_BIT]   = r.show_user;
                    next_r.rd_data[ST_RECOUT_BIT]    = ~rec_en;
                    next_r.rd_data[ST_STEP_LSB +: 3] = r.step;
                end
                ADDR_RC_CNT:
                begin
                    next_r.rd_data[15:0] = r.rc_cnt;
                end
                ADDR_OC_CNT:
                begin
                    next_r.rd_data[15:0] = r.oc_cnt;
                end
                default:
                begin
                    next_r.rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            r      <= '0;
            r.li   <= LI_DEFAULT;
            r.seq  <= SEQ_IDLE;
            r.sup  <= SUP_NONE;
            r.ctrl <= CTRL_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_enable.phase_dir_toc   = r.li.phase_dir_toc_enable;
    assign o_enable.ground_dir_toc  = r.li.ground_dir_toc_enable;
    assign o_enable.sensitive_earth = r.li.sensitive_earth_enable & r.ctrl[CTRL_SEF_BIT];
    assign o_enable.recloser        = rec_en;
    assign o_user_logic_inputs      = r.li.user_logic_inputs;
    assign o_breaker                = pos;
    assign o_display_user_msg       = r.show_user;
    assign o_display_cb_unknown     = pos.unknown;
    assign o_recloser_out_target    = ~rec_en;
    assign o_bf_external_start      = r.li.external_failure_starter;
    assign o_bf_initiate            = r.li.failure_trip_initiate;
    assign o_trip                   = r.trip;
    assign o_close                  = r.close;
    assign o_trip_fail              = r.trip_fail;
    assign o_close_fail             = r.close_fail;
    assign o_recloser_step          = r.step;
    assign o_rd_data                = r.rd_data;

endmodule

// *** verif/rlic_checker.sv ***
/*
  Port checker of the logical-input control block.
  Assumes it is bound to rlic_top and that inputs are resolved one cycle early.
*/
`timescale 1ns/1ns
module rlic_checker
    import rlic_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire rlic_li_t    i_li_value,
    input wire rlic_li_t    i_li_mapped,
    input wire logic [7:0]  i_addr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rd_data,
    input wire rlic_en_t    o_enable,
    input wire logic [15:0] o_user_logic_inputs,
    input wire rlic_pos_t   o_breaker,
    input wire logic        o_display_user_msg,
    input wire logic        o_display_cb_unknown,
    input wire logic        o_recloser_out_target,
    input wire logic        o_bf_external_start,
    input wire logic        o_bf_initiate,
    input wire logic        o_trip
);
    rlic_li_t eff;
    // Unmapped inputs fall back to their defaults
    assign eff = (i_li_value & i_li_mapped) | (LI_DEFAULT & ~i_li_mapped);

    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence clear_held;
        eff.counter_clear_input [*3];
    endsequence
    sequence msg_off;
        !eff.user_message_input [*2];
    endsequence

    chk_phase_enable: assert property (
        $past(i_rst_b) |-> o_enable.phase_dir_toc == $past(eff.phase_dir_toc_enable))
        else $error("phase enable wrong");
    chk_ground_enable: assert property (
        $past(i_rst_b) |-> o_enable.ground_dir_toc == $past(eff.ground_dir_toc_enable))
        else $error("ground enable wrong");
    chk_user_inputs: assert property (
        $past(i_rst_b) |-> o_user_logic_inputs == $past(eff.user_logic_inputs))
        else $error("user inputs wrong");
    chk_counter_clear: assert property (
        clear_held ##0 (i_rd && (i_addr == ADDR_RC_CNT || i_addr == ADDR_OC_CNT)) |=> o_rd_data == 32'h0)
        else $error("counter not cleared");
    chk_msg_off: assert property (
        msg_off |=> !o_display_user_msg)
        else $error("user message shown while off");
    chk_failure_starts: assert property (
        $past(i_rst_b) |-> o_bf_external_start == $past(eff.external_failure_starter)
            && o_bf_initiate == $past(eff.failure_trip_initiate))
        else $error("failure start wrong");
    chk_trip_pulse: assert property (
        o_trip |=> !o_trip)
        else $error("trip longer than one cycle");
    chk_aux_closed: assert property (
        $past(i_rst_b) && $past(eff.breaker_aux_a) && !$past(eff.breaker_aux_b)
            |-> o_breaker.closed && !o_breaker.open && !o_breaker.unknown)
        else $error("closed not decoded");
    chk_aux_open: assert property (
        $past(i_rst_b) && !$past(eff.breaker_aux_a) && $past(eff.breaker_aux_b)
            |-> o_breaker.open && !o_breaker.closed && !o_breaker.unknown)
        else $error("open not decoded");
    chk_unknown_shown: assert property (
        o_display_cb_unknown == !(o_breaker.closed ^ o_breaker.open))
        else $error("unknown not displayed");
    chk_recloser_target: assert property (
        $past(i_rst_b) |-> o_recloser_out_target == !$past(eff.recloser_enable)
            && o_enable.recloser == $past(eff.recloser_enable))
        else $error("recloser target wrong");
    chk_read_idle: assert property (
        !i_rd |=> o_rd_data == 32'h0)
        else $error("read data without read");
endmodule

// *** verif/rlic_breaker_model.sv ***
/*
  Breaker with two auxiliary contacts, driven by the relay's trip and close.
  Assumes one-cycle command pulses; a stuck breaker ignores commands.
*/
`timescale 1ns/1ns
module rlic_breaker_model #(
    parameter int P_TRAVEL = 3
)
(
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_trip,
    input  wire logic i_close,
    input  wire logic i_stuck,
    output logic      o_aux_a,
    output logic      o_aux_b
);
    logic closed;
    logic to_closed;
    int   travel;
    // Contacts move only after the mechanism travel time
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            closed    <= 1'b1;
            to_closed <= 1'b1;
            travel    <= 0;
        end
        else if ((i_trip || i_close) && !i_stuck)
        begin
            to_closed <= i_close;
            travel    <= P_TRAVEL;
        end
        else if (travel == 1)
        begin
            closed <= to_closed;
            travel <= 0;
        end
        else if (travel > 0)
            travel <= travel - 1;
    end
    assign o_aux_a = closed;
    assign o_aux_b = !closed;
endmodule

// *** verif/test_relay_logical_input_control.sv ***
/*
  Testbench of the logical-input control block with a breaker model.
  Assumes shortened timing parameters for simulation.
*/
`timescale 1ns/1ns
module test_relay_logical_input_control;
    import rlic_pkg::*;
    localparam int OPN = 10, RST = 30, ALT = 20, FAIL = 8, LIMIT = 20000;
    logic        i_clk = 0, i_rst_b = 0, i_close_cmd = 0, i_overcurrent_trip = 0, i_wr = 0, i_rd = 0;
    logic [7:0]  i_addr = 0;
    logic [31:0] i_wr_data = 0, o_rd_data;
    rlic_li_t    li_v = '0, li_m = '0, li_in;
    rlic_en_t    o_enable;
    rlic_pos_t   o_breaker;
    logic [15:0] o_user_logic_inputs;
    logic [2:0]  o_recloser_step;
    logic        o_display_user_msg, o_display_cb_unknown, o_recloser_out_target, o_bf_external_start;
    logic        o_bf_initiate, o_trip, o_close, o_trip_fail, o_close_fail, m_a, m_b;
    logic        use_model = 0, stuck = 0;
    int          n_errors = 0, checks = 0, cyc = 0, n_trip = 0, n_close = 0, t_trip = 0, t_close = 0;
    int          n0, c0, n;

    always #2 i_clk = ~i_clk;

    rlic_top #(.P_ALT_CYC(ALT), .P_OPEN_CYC(OPN), .P_RESET_CYC(RST), .P_FAIL_CYC(FAIL)) i_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_li_value(li_in), .i_li_mapped(li_m),
        .i_close_cmd(i_close_cmd), .i_overcurrent_trip(i_overcurrent_trip), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_enable(o_enable),
        .o_user_logic_inputs(o_user_logic_inputs), .o_breaker(o_breaker),
        .o_display_user_msg(o_display_user_msg), .o_display_cb_unknown(o_display_cb_unknown),
        .o_recloser_out_target(o_recloser_out_target), .o_bf_external_start(o_bf_external_start),
        .o_bf_initiate(o_bf_initiate), .o_trip(o_trip), .o_close(o_close), .o_trip_fail(o_trip_fail),
        .o_close_fail(o_close_fail), .o_recloser_step(o_recloser_step));

    rlic_breaker_model i_brk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_trip(o_trip), .i_close(o_close),
        .i_stuck(stuck), .o_aux_a(m_a), .o_aux_b(m_b));

    always_comb
    begin
        li_in = li_v;
        if (use_model)
        begin
            li_in.breaker_aux_a = m_a;
            li_in.breaker_aux_b = m_b;
        end
    end

    // Event log and hang guard
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (o_trip)
        begin
            n_trip <= n_trip + 1;
            t_trip <= cyc;
        end
        if (o_close)
        begin
            n_close <= n_close + 1;
            t_close <= cyc;
        end
        if (cyc == LIMIT)
        begin
            n_errors++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr    <= a;
        i_wr_data <= d;
        i_wr      <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 check(what, o_rd_data, exp);
    endtask

    task automatic pulse_test;
        tick(1);
        li_v.trip_reclose_test <= 1'b1;
        tick(1);
        li_v.trip_reclose_test <= 1'b0;
    endtask

    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        tick(16);
        i_rst_b <= 1'b1;
        tick(2);
        #1 check("enables", 32'(o_enable), 32'hf);
        check("user", 32'(o_user_logic_inputs), 32'h0);
        check("pos", 32'(o_breaker), 32'h1);
        check("bf", 32'({o_bf_external_start, o_bf_initiate}), 32'h0);
        rd(ADDR_CTRL, 32'h2, "ctrl");
        wr(ADDR_STATUS, 32'hff);
        rd(8'h10, 32'h0, "unmapped");
        rd(ADDR_STATUS, 32'h4, "status");
        tick(1);
        li_m <= '1;
        li_v.user_logic_inputs        <= 16'ha5c3;
        li_v.external_failure_starter <= 1'b1;
        li_v.failure_trip_initiate    <= 1'b1;
        li_v.breaker_aux_a            <= 1'b1;
        tick(2);
        #1 check("en off", 32'({o_enable, o_recloser_out_target}), 32'h1);
        check("user", 32'(o_user_logic_inputs), 32'ha5c3);
        check("bf", 32'({o_bf_external_start, o_bf_initiate}), 32'h3);
        check("closed", 32'(o_breaker), 32'h4);
        tick(1);
        li_v.breaker_aux_b   <= 1'b1;
        li_v.recloser_enable <= 1'b1;
        tick(2);
        #1 check("same", 32'({o_breaker, o_display_cb_unknown}), 32'h3);
        wr(ADDR_CTRL, 32'h3);
        tick(1);
        #1 check("single", 32'(o_breaker), 32'h4);
        wr(ADDR_CTRL, 32'h2);
        li_v.breaker_aux_a <= 1'b0;
        li_v.breaker_aux_b <= 1'b0;
        tick(1);
        i_close_cmd <= 1'b1;
        tick(1);
        i_close_cmd <= 1'b0;
        rd(ADDR_STATUS, 32'hc, "pending");
        c0 = n_close;
        li_v.breaker_aux_b <= 1'b1;
        tick(5);
        check("held close", 32'(n_close - c0), 32'h1);
        tick(1);
        use_model <= 1'b1;
        tick(4);
        n0 = n_trip;
        c0 = n_close;
        pulse_test();
        tick(OPN + RST + 20);
        check("one shot", 32'({16'(n_trip - n0), 16'(n_close - c0)}), {16'h1, 16'h1});
        check("step idle", 32'(o_recloser_step), 32'h0);
        pulse_test();
        for (n = 0; n < 20 && n_trip == n0 + 1; n++)
            tick(1);
        tick(2);
        li_v.reclose_inhibit <= 1'b1;
        tick(15);
        li_v.reclose_inhibit <= 1'b0;
        for (n = 0; n < 60 && n_close == c0 + 1; n++)
            tick(1);
        li_v.reclose_inhibit <= 1'b1;
        #1 check("frozen", 32'(t_close - t_trip), 32'(OPN + 15));
        tick(RST - 4);
        #1 check("step", 32'(o_recloser_step), 32'h1);
        tick(8);
        #1 check("reset tmr", 32'(o_recloser_step), 32'h0);
        tick(1);
        li_v.reclose_inhibit   <= 1'b0;
        li_v.trip_reclose_test <= 1'b1;
        n0 = n_trip;
        tick(120);
        #1 check("held", 32'({n_trip - n0, 13'h0, o_recloser_step}), {16'h4, 13'h0, MAX_STEPS});
        tick(1);
        li_v.trip_reclose_test <= 1'b0;
        tick(OPN + RST + 20);
        rd(ADDR_RC_CNT, 32'h6, "rc count");
        stuck <= 1'b1;
        pulse_test();
        tick(FAIL + 6);
        #1 check("trip fail", 32'({o_trip_fail, o_close_fail}), 32'h2);
        tick(1);
        stuck <= 1'b0;
        tick(OPN + RST + 20);
        repeat (3)
        begin
            tick(1);
            i_overcurrent_trip <= 1'b1;
            tick(1);
            i_overcurrent_trip <= 1'b0;
        end
        rd(ADDR_OC_CNT, 32'h3, "oc count");
        li_v.counter_clear_input <= 1'b1;
        tick(4);
        rd(ADDR_RC_CNT, 32'h0, "rc clear");
        rd(ADDR_OC_CNT, 32'h0, "oc clear");
        li_v.counter_clear_input <= 1'b0;
        li_v.user_message_input  <= 1'b1;
        for (n = 0; n < 3 * ALT && o_display_user_msg !== 1'b1; n++)
            #4;
        #1 n = 0;
        while (o_display_user_msg === 1'b1 && n < 100)
        begin
            tick(1);
            #1 n++;
        end
        check("msg period", 32'(n), 32'(ALT));
        li_v.user_message_input     <= 1'b0;
        li_v.sensitive_earth_enable <= 1'b1;
        wr(ADDR_CTRL, 32'h0);
        tick(2);
        #1 check("sef model", 32'({o_display_user_msg, o_enable.sensitive_earth}), 32'h0);
        wr(ADDR_CTRL, 32'h2);
        tick(1);
        #1 check("sef on", 32'(o_enable.sensitive_earth), 32'h1);
        conclude();
    end
endmodule

bind rlic_top rlic_checker i_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_li_value(i_li_value), .i_li_mapped(i_li_mapped),
    .i_addr(i_addr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_enable(o_enable),
    .o_user_logic_inputs(o_user_logic_inputs), .o_breaker(o_breaker),
    .o_display_user_msg(o_display_user_msg), .o_display_cb_unknown(o_display_cb_unknown),
    .o_recloser_out_target(o_recloser_out_target), .o_bf_external_start(o_bf_external_start),
    .o_bf_initiate(o_bf_initiate), .o_trip(o_trip));
